// ===== core/wdt_pkg.sv
// Purpose: shared constants and types for the standalone watchdog
// Assumes: 32-bit register port, byte addresses, 16-bit registers in the low half
// Notes:   slow oscillator nominally 128 kHz, sampled as a level on CLK
package wdt_pkg;

   // register map (byte addresses)
   localparam logic [31:0] KEY_ADDR       = 32'h4000_3000;
   localparam logic [31:0] DIVIDER_ADDR   = 32'h4000_3004;
   localparam logic [31:0] RELOAD_ADDR    = 32'h4000_3008;
   localparam logic [31:0] STATUS_ADDR    = 32'h4000_300c;

   // key values
   localparam logic [15:0] KEY_FEED       = 16'haaaa;
   localparam logic [15:0] KEY_UNLOCK     = 16'h5555;
   localparam logic [15:0] KEY_START      = 16'hcccc;

   // field layout and reset values
   localparam int          CNT_W          = 12;
   localparam int          DIV_W          = 3;
   localparam logic [11:0] RELOAD_RESET   = 12'hfff;
   localparam logic [11:0] DIVIDER_RESET  = 12'h000;
   localparam int          STAT_DIV_BIT   = 0;
   localparam int          STAT_RELOAD_BIT = 1;

   // slow-clock ticks an update takes to settle (limit is 5)
   localparam logic [2:0]  SYNC_TICKS     = 3'h3;
   localparam int          SYNC_LIMIT     = 5;
   localparam int          SLOW_OSC_KHZ   = 128;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_type;

   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_FIRED} mode_type;

   typedef struct packed {
      mode_type    mode;
      logic        unlocked;
      logic [11:0] count;
      logic        slow_prev;
      logic        cause_flag;
      logic [31:0] rdata;
   } main_state_type;

   typedef struct packed {
      logic        busy;
      logic [2:0]  ticks;
      logic [11:0] shadow;
      logic [11:0] applied;
   } pend_state_type;

   typedef struct packed {
      logic [7:0]  cnt;
      logic        tick;
   } presc_state_type;

endpackage : wdt_pkg

// ===== core/wdt_prescaler.sv
// Purpose: divides slow-oscillator ticks into counting ticks
// Assumes: slow_tick is a one-cycle pulse per slow-oscillator period
// Notes:   count_tick is a registered one-cycle pulse
`timescale 1ns/1ps
module wdt_prescaler
   import wdt_pkg::*;
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // slow ticks in, divided ticks out
   input  wire logic             slow_tick,
   input  wire logic [DIV_W-1:0] code,
   output logic                  count_tick
);

   presc_state_type st_q;
   presc_state_type st_d;

   function automatic logic [8:0] div_of(input logic [2:0] c);
      div_of = (c == 3'h7) ? 9'h100 : (9'h004 << c);
   endfunction : div_of

   always_comb begin
      st_d      = st_q;
      st_d.tick = 1'b0;
      if (slow_tick) begin
         // greater-or-equal keeps a shrinking divider from overrunning
         if ({1'b0, st_q.cnt} >= (div_of(code) - 9'h001)) begin
            st_d.cnt  = 8'h00;
            st_d.tick = 1'b1;
         end else begin
            st_d.cnt = st_q.cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign count_tick = st_q.tick;

   a_div_range: assert property (@(posedge clk) disable iff (rst)
      slow_tick |=> {1'b0, st_q.cnt} < div_of($past(code)))
      else $error("prescaler count beyond divider");

endmodule : wdt_prescaler

// ===== core/wdt_top.sv
// Purpose: standalone watchdog, 12-bit down counter on a divided slow oscillator
// Assumes: all inputs synchronous to CLK; SLOW_OSC is a level sampled on CLK
// Notes:   reset request holds until SYS_RST; cause flag survives SYS_RST
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module wdt_top
   import wdt_pkg::*;
(
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   input  wire logic        POWER_ON_RST,
   // register port
   input  wire logic [31:0] REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic [31:0]      REG_RDATA,
   // slow oscillator
   input  wire logic        SLOW_OSC,
   input  wire logic        SLOW_OSC_READY,
   // system controls
   input  wire logic        HARDWARE_START_OPTION,
   input  wire logic        DEBUG_HALT,
   input  wire logic        DEBUG_FREEZE_SEL,
   input  wire logic        RESET_FLAG_CLEAR,
   // results
   output logic             WDT_RESET_REQ,
   output logic             WDT_RUNNING,
   output logic             WATCHDOG_RESET_CAUSE_FLAG
);

   localparam main_state_type MAIN_RESET = '{
      mode:       ST_IDLE,
      unlocked:   1'b0,
      count:      RELOAD_RESET,
      slow_prev:  1'b0,
      cause_flag: 1'b0,
      rdata:      32'h0000_0000
   };

   main_state_type st_q;
   main_state_type st_d;
   reg_req_type    req;

   logic        slow_tick;
   logic        count_tick;
   logic        frozen;
   logic        key_wr;
   logic [15:0] key_val;
   logic        div_load;
   logic        reload_load;
   logic        div_busy;
   logic        reload_busy;
   logic [11:0] div_shadow;
   logic [11:0] div_applied;
   logic [11:0] reload_shadow;
   logic [11:0] reload_applied;

   assign req = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};

   function automatic logic hit(input reg_req_type r, input logic [31:0] a);
      hit = (r.addr == a);
   endfunction : hit

   // rising edge of the sampled slow oscillator, only once it is stable
   assign slow_tick = SLOW_OSC & ~st_q.slow_prev & SLOW_OSC_READY;

   assign frozen  = DEBUG_HALT & DEBUG_FREEZE_SEL;
   assign key_wr  = req.wr & hit(req, KEY_ADDR);
   assign key_val = req.wdata[15:0];

   // writes need the unlock and no update in flight
   assign div_load    = req.wr & hit(req, DIVIDER_ADDR) & st_q.unlocked
                        & ~div_busy;
   assign reload_load = req.wr & hit(req, RELOAD_ADDR) & st_q.unlocked
                        & ~reload_busy;

   wdt_prescaler u_prescaler (
      .clk        (CLK),
      .rst        (SYS_RST),
      .slow_tick  (slow_tick),
      .code       (div_applied[DIV_W-1:0]),
      .count_tick (count_tick)
   );

   wdt_update_sync #(
      .INIT (DIVIDER_RESET)
   ) u_div_sync (
      .clk        (CLK),
      .rst        (SYS_RST),
      .slow_tick  (slow_tick),
      .load       (div_load),
      .load_value ({9'h000, req.wdata[DIV_W-1:0]}),
      .busy       (div_busy),
      .shadow     (div_shadow),
      .applied    (div_applied)
   );

   wdt_update_sync #(
      .INIT (RELOAD_RESET)
   ) u_reload_sync (
      .clk        (CLK),
      .rst        (SYS_RST),
      .slow_tick  (slow_tick),
      .load       (reload_load),
      .load_value (req.wdata[CNT_W-1:0]),
      .busy       (reload_busy),
      .shadow     (reload_shadow),
      .applied    (reload_applied)
   );

   always_comb begin
      st_d           = st_q;
      st_d.rdata     = 32'h0000_0000;
      st_d.slow_prev = SLOW_OSC;

      // key register: only the three keys act
      if (key_wr) begin
         case (key_val)
            KEY_UNLOCK: st_d.unlocked = 1'b1;
            KEY_FEED:   st_d.unlocked = 1'b0;
            KEY_START:  st_d.unlocked = 1'b0;
            default:    st_d.unlocked = st_q.unlocked;
         endcase
      end

      case (st_q.mode)
         ST_IDLE: begin
            if (HARDWARE_START_OPTION
                || (key_wr && key_val == KEY_START)) begin
               st_d.mode  = ST_RUN;
               st_d.count = reload_applied;
            end
         end
         ST_RUN: begin
            if (key_wr && key_val == KEY_FEED) begin
               st_d.count = reload_applied;
            end else if (count_tick && !frozen) begin
               if (st_q.count == 12'h000) begin
                  st_d.mode = ST_FIRED;
               end else begin
                  st_d.count = st_q.count - 12'h001;
               end
            end
         end
         ST_FIRED: begin
            st_d.mode = ST_FIRED;
         end
         default: begin
            st_d.mode = ST_IDLE;
         end
      endcase

      // cause flag: a new firing wins over a clear in the same cycle
      if (POWER_ON_RST) begin
         st_d.cause_flag = 1'b0;
      end else if (st_q.mode == ST_FIRED) begin
         st_d.cause_flag = 1'b1;
      end else if (RESET_FLAG_CLEAR) begin
         st_d.cause_flag = 1'b0;
      end

      // read data, reserved bits zero, key register reads zero
      if (req.rd) begin
         if (hit(req, DIVIDER_ADDR)) begin
            st_d.rdata = {29'h0, div_shadow[DIV_W-1:0]};
         end else if (hit(req, RELOAD_ADDR)) begin
            st_d.rdata = {20'h0, reload_shadow};
         end else if (hit(req, STATUS_ADDR)) begin
            st_d.rdata = {30'h0, reload_busy, div_busy};
         end else begin
            st_d.rdata = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         st_q            <= MAIN_RESET;
         st_q.cause_flag <= st_d.cause_flag;
      end else begin
         st_q <= st_d;
      end
   end

   assign REG_RDATA                 = st_q.rdata;
   assign WDT_RESET_REQ             = (st_q.mode == ST_FIRED);
   assign WDT_RUNNING               = (st_q.mode != ST_IDLE);
   assign WATCHDOG_RESET_CAUSE_FLAG = st_q.cause_flag;

   // checks

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   sequence s_feed;
      key_wr && key_val == KEY_FEED && st_q.mode == ST_RUN;
   endsequence

   sequence s_last_tick;
      st_q.mode == ST_RUN && count_tick && !frozen && st_q.count == 12'h000
      && !(key_wr && key_val == KEY_FEED);
   endsequence

   sequence s_unlocked_div_write;
      req.wr && hit(req, DIVIDER_ADDR) && st_q.unlocked && !div_busy;
   endsequence

   sequence s_key_write(logic [15:0] k);
      key_wr && key_val == k;
   endsequence

   a_fire_on_zero: assert property (s_last_tick |=> WDT_RESET_REQ)
      else $error("no reset request at zero");

   a_no_early_fire: assert property (
      st_q.mode == ST_RUN && !(count_tick && st_q.count == 12'h000)
      |=> !WDT_RESET_REQ)
      else $error("reset request before counter expired");

   a_feed_loads: assert property (s_feed |=> st_q.count == $past(reload_applied))
      else $error("feed did not load reload value");

   a_start_key: assert property (
      key_wr && key_val == KEY_START |=> WDT_RUNNING)
      else $error("start key did not start watchdog");

   a_run_sticky: assert property (WDT_RUNNING |=> WDT_RUNNING)
      else $error("watchdog stopped without reset");

   a_hw_start: assert property (HARDWARE_START_OPTION |=> WDT_RUNNING)
      else $error("hardware start option ignored");

   a_locked_div: assert property (
      req.wr && hit(req, DIVIDER_ADDR) && !st_q.unlocked
      |=> $stable(div_shadow))
      else $error("divider written without unlock");

   a_unlock_write: assert property (
      s_unlocked_div_write |=> div_busy ##0 div_shadow[DIV_W-1:0]
      == $past(req.wdata[DIV_W-1:0]))
      else $error("unlocked divider write lost");

   a_step_down: assert property (
      st_q.mode == ST_RUN && count_tick && !frozen && st_q.count != 12'h000
      && !(key_wr && key_val == KEY_FEED)
      |=> st_q.count == $past(st_q.count) - 12'h001)
      else $error("counter did not step by one");

   a_debug_freeze: assert property (
      st_q.mode == ST_RUN && frozen && !(key_wr && key_val == KEY_FEED)
      |=> $stable(st_q.count))
      else $error("counter moved while frozen");

   a_status_read: assert property (
      req.rd && hit(req, STATUS_ADDR)
      |=> REG_RDATA == {30'h0, $past(reload_busy), $past(div_busy)})
      else $error("status read mismatch");

   a_reload_upper: assert property (
      req.rd && hit(req, RELOAD_ADDR) |=> REG_RDATA[31:12] == 20'h0)
      else $error("reload upper bits not zero");

   a_key_reads_zero: assert property (
      req.rd && hit(req, KEY_ADDR) |=> REG_RDATA == 32'h0)
      else $error("key register read not zero");

   a_cause_set: assert property (disable iff (1'b0)
      WDT_RESET_REQ && !POWER_ON_RST |=> WATCHDOG_RESET_CAUSE_FLAG)
      else $error("cause flag not set on firing");

   a_osc_gate: assert property (!SLOW_OSC_READY |-> !slow_tick)
      else $error("tick from unstable oscillator");

   a_locked_reload: assert property (
      req.wr && hit(req, RELOAD_ADDR) && !st_q.unlocked |=> $stable(reload_shadow))
      else $error("reload written without unlock");

   a_reload_accept: assert property (
      req.wr && hit(req, RELOAD_ADDR) && st_q.unlocked && !reload_busy
      |=> reload_busy ##0 reload_shadow == $past(req.wdata[CNT_W-1:0]))
      else $error("unlocked reload write lost");

   a_busy_reload: assert property (
      req.wr && hit(req, RELOAD_ADDR) && reload_busy |=> $stable(reload_shadow))
      else $error("reload changed while update pending");

   a_unlock_key: assert property (s_key_write(KEY_UNLOCK) |=> st_q.unlocked)
      else $error("unlock key did not unlock");

   a_feed_relocks: assert property (s_key_write(KEY_FEED) |=> !st_q.unlocked)
      else $error("feed key left registers unlocked");

   a_odd_key: assert property (
      key_wr && key_val != KEY_FEED && key_val != KEY_UNLOCK && key_val != KEY_START
      && !HARDWARE_START_OPTION |=> $stable(st_q.unlocked) && $stable(WDT_RUNNING))
      else $error("unknown key had an effect");

   a_idle_stays: assert property (
      st_q.mode == ST_IDLE && !HARDWARE_START_OPTION && !(key_wr && key_val == KEY_START)
      |=> !WDT_RUNNING)
      else $error("watchdog started without start key");

   a_start_loads: assert property (
      st_q.mode == ST_IDLE && key_wr && key_val == KEY_START
      |=> st_q.count == $past(reload_applied))
      else $error("start key did not load reload value");

   a_req_sticky: assert property (WDT_RESET_REQ |=> WDT_RESET_REQ)
      else $error("reset request dropped without reset");

   a_rdata_quiet: assert property (!req.rd |=> REG_RDATA == 32'h0000_0000)
      else $error("read data outside a read");

   a_div_read: assert property (
      req.rd && hit(req, DIVIDER_ADDR)
      |=> REG_RDATA == {29'h0, $past(div_shadow[DIV_W-1:0])})
      else $error("divider read mismatch");

   a_reload_read: assert property (
      req.rd && hit(req, RELOAD_ADDR) |=> REG_RDATA == {20'h0, $past(reload_shadow)})
      else $error("reload read mismatch");

   a_cause_clear: assert property (disable iff (1'b0)
      RESET_FLAG_CLEAR && !WDT_RESET_REQ |=> !WATCHDOG_RESET_CAUSE_FLAG)
      else $error("cause flag not cleared");

   a_por_clear: assert property (disable iff (1'b0)
      POWER_ON_RST |=> !WATCHDOG_RESET_CAUSE_FLAG)
      else $error("power-on reset left cause flag set");

endmodule : wdt_top

// ===== core/wdt_update_sync.sv
// Purpose: holds a written value and applies it to the counting side after settling
// Assumes: load is only raised while busy is low
// Notes:   busy is the pending flag shown in the status register
`timescale 1ns/1ps
module wdt_update_sync
   import wdt_pkg::*;
#(
   parameter logic [11:0] INIT = 12'h000
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // slow ticks drive the settling
   input  wire logic        slow_tick,
   // new value from software
   input  wire logic        load,
   input  wire logic [11:0] load_value,
   // state
   output logic             busy,
   output logic [11:0]      shadow,
   output logic [11:0]      applied
);

   pend_state_type st_q;
   pend_state_type st_d;

   always_comb begin
      st_d = st_q;
      if (load) begin
         st_d.busy   = 1'b1;
         st_d.ticks  = 3'h0;
         st_d.shadow = load_value;
      end else if (st_q.busy && slow_tick) begin
         // completes on slow ticks alone, whatever the system does
         if (st_q.ticks == (SYNC_TICKS - 3'h1)) begin
            st_d.busy    = 1'b0;
            st_d.applied = st_q.shadow;
         end else begin
            st_d.ticks = st_q.ticks + 3'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= '{busy: 1'b0, ticks: 3'h0, shadow: INIT, applied: INIT};
      end else begin
         st_q <= st_d;
      end
   end

   assign busy    = st_q.busy;
   assign shadow  = st_q.shadow;
   assign applied = st_q.applied;

   a_settle_bound: assert property (@(posedge clk) disable iff (rst)
      st_q.busy |-> st_q.ticks < 3'(SYNC_LIMIT))
      else $error("update settling exceeds limit");

endmodule : wdt_update_sync

// ===== sim/tb.sv
// Purpose: self-checking bench for the standalone watchdog top
// Assumes: slow oscillator modelled as one rising edge every 8 CLK cycles
// Notes:   one row per divider code, then hand tests for reset, locking and holds
`timescale 1ns/1ps
module tb
   import wdt_pkg::*;
;
   typedef struct packed {
      logic [2:0]  code;
      logic [11:0] rel;
      int          div;
   } row_type;

   logic        CLK                       = 1'b0;
   logic        SYS_RST                   = 1'b1;
   logic        POWER_ON_RST              = 1'b1;
   logic [31:0] REG_ADDR                  = 32'h0;
   logic [31:0] REG_WDATA                 = 32'h0;
   logic        REG_WR                    = 1'b0;
   logic        REG_RD                    = 1'b0;
   logic [31:0] REG_RDATA;
   logic        SLOW_OSC;
   logic        SLOW_OSC_READY            = 1'b1;
   logic        HARDWARE_START_OPTION     = 1'b0;
   logic        DEBUG_HALT                = 1'b0;
   logic        DEBUG_FREEZE_SEL          = 1'b0;
   logic        RESET_FLAG_CLEAR          = 1'b0;
   logic        WDT_RESET_REQ;
   logic        WDT_RUNNING;
   logic        WATCHDOG_RESET_CAUSE_FLAG;
   logic [2:0]  slow_div                  = 3'h0;
   logic [31:0] d;
   int          num_errors                = 0;
   int          n_tests                   = 0;
   int          n;
   int          lo;
   int          hi;
   row_type     rows [8] = '{'{3'h0, 12'h3, 4}, '{3'h1, 12'h2, 8}, '{3'h2, 12'h1, 16},
                             '{3'h3, 12'h1, 32}, '{3'h4, 12'h1, 64}, '{3'h5, 12'h1, 128},
                             '{3'h6, 12'h1, 256}, '{3'h7, 12'h1, 256}};

   always #5 CLK = ~CLK;

   // slow oscillator: rising edge every 8 CLK cycles
   always @(posedge CLK) begin
      slow_div <= slow_div + 3'h1;
   end
   assign SLOW_OSC = slow_div[2];

   wdt_top wdt_top_i (
      .CLK                       (CLK),
      .SYS_RST                   (SYS_RST),
      .POWER_ON_RST              (POWER_ON_RST),
      .REG_ADDR                  (REG_ADDR),
      .REG_WDATA                 (REG_WDATA),
      .REG_WR                    (REG_WR),
      .REG_RD                    (REG_RD),
      .REG_RDATA                 (REG_RDATA),
      .SLOW_OSC                  (SLOW_OSC),
      .SLOW_OSC_READY            (SLOW_OSC_READY),
      .HARDWARE_START_OPTION     (HARDWARE_START_OPTION),
      .DEBUG_HALT                (DEBUG_HALT),
      .DEBUG_FREEZE_SEL          (DEBUG_FREEZE_SEL),
      .RESET_FLAG_CLEAR          (RESET_FLAG_CLEAR),
      .WDT_RESET_REQ             (WDT_RESET_REQ),
      .WDT_RUNNING               (WDT_RUNNING),
      .WATCHDOG_RESET_CAUSE_FLAG (WATCHDOG_RESET_CAUSE_FLAG)
   );

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report

   task automatic cyc(input int k);
      repeat (k) @(posedge CLK);
      #1;
   endtask : cyc

   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      @(posedge CLK);
      REG_ADDR  <= a;
      REG_WDATA <= v;
      REG_WR    <= 1'b1;
      @(posedge CLK);
      REG_WR    <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [31:0] a, output logic [31:0] v);
      @(posedge CLK);
      REG_ADDR <= a;
      REG_RD   <= 1'b1;
      @(posedge CLK);
      REG_RD   <= 1'b0;
      #1;
      v = REG_RDATA;
   endtask : rd

   task automatic sys_reset();
      @(posedge CLK);
      SYS_RST <= 1'b1;
      cyc(16);
      @(posedge CLK);
      SYS_RST <= 1'b0;
      #1;
   endtask : sys_reset

   // waits for the reset request, at most limit cycles
   task automatic wait_fire(input int limit, output int k);
      k = 0;
      while (WDT_RESET_REQ !== 1'b1 && k < limit) begin
         @(posedge CLK);
         #1;
         k++;
      end
   endtask : wait_fire

   initial begin
      #400000;
      num_errors++;
      final_report();
   end

   initial begin
      cyc(16);
      SYS_RST      <= 1'b0;
      POWER_ON_RST <= 1'b0;
      chk("cause_por", WATCHDOG_RESET_CAUSE_FLAG, 32'h0);
      foreach (rows[i]) begin
         sys_reset();
         wr(KEY_ADDR, {16'h0, KEY_UNLOCK});
         wr(DIVIDER_ADDR, {29'h0, rows[i].code});
         wr(RELOAD_ADDR, {20'h0, rows[i].rel});
         cyc(48);
         rd(DIVIDER_ADDR, d);
         chk("divider", d, {29'h0, rows[i].code});
         rd(STATUS_ADDR, d);
         chk("status", d, 32'h0);
         wr(KEY_ADDR, {16'h0, KEY_START});
         // first decrement lands within one divided period of the start key
         lo = int'(rows[i].rel) * rows[i].div * 8 + 1;
         hi = lo + rows[i].div * 8 - 1;
         wait_fire(hi + 8, n);
         chk("running", WDT_RUNNING, 32'h1);
         chk("fire_time", {31'h0, n >= lo && n <= hi}, 32'h1);
         cyc(20);
         chk("req_held", WDT_RESET_REQ, 32'h1);
         sys_reset();
         chk("cause_set", WATCHDOG_RESET_CAUSE_FLAG, 32'h1);
         RESET_FLAG_CLEAR <= 1'b1;
         cyc(1);
         RESET_FLAG_CLEAR <= 1'b0;
         cyc(2);
         chk("cause_clr", WATCHDOG_RESET_CAUSE_FLAG, 32'h0);
      end
      // reset values, key reads zero, unmapped reads zero
      sys_reset();
      rd(KEY_ADDR, d);
      chk("key_rd", d, 32'h0);
      rd(DIVIDER_ADDR, d);
      chk("div_rst", d, 32'h0);
      rd(RELOAD_ADDR, d);
      chk("rel_rst", d, 32'h0fff);
      rd(32'h4000_3010, d);
      chk("unmapped", d, 32'h0);
      chk("idle_run", WDT_RUNNING, 32'h0);
      // locked writes and unknown keys are dropped
      wr(KEY_ADDR, 32'h1234);
      wr(RELOAD_ADDR, 32'h5);
      wr(DIVIDER_ADDR, 32'h5);
      wr(STATUS_ADDR, 32'h3);
      rd(RELOAD_ADDR, d);
      chk("rel_locked", d, 32'h0fff);
      rd(STATUS_ADDR, d);
      chk("stat_ro", d, 32'h0);
      rd(DIVIDER_ADDR, d);
      chk("div_locked", d, 32'h0);
      // pending flags, reserved bits, write while pending ignored
      wr(KEY_ADDR, {16'h0, KEY_UNLOCK});
      wr(DIVIDER_ADDR, 32'h1);
      rd(STATUS_ADDR, d);
      chk("div_pend", d, 32'h1);
      wr(RELOAD_ADDR, 32'hffff_f003);
      wr(RELOAD_ADDR, 32'h456);
      rd(STATUS_ADDR, d);
      chk("both_pend", d, 32'h3);
      cyc(40);
      rd(STATUS_ADDR, d);
      chk("pend_done", d, 32'h0);
      rd(RELOAD_ADDR, d);
      chk("rel_field", d, 32'h003);
      cyc(300);
      chk("no_start", WDT_RESET_REQ, 32'h0);
      // feeding keeps it alive, then it fires
      wr(KEY_ADDR, {16'h0, KEY_START});
      repeat (6) begin
         cyc(100);
         wr(KEY_ADDR, {16'h0, KEY_FEED});
      end
      chk("fed", WDT_RESET_REQ, 32'h0);
      wait_fire(270, n);
      chk("unfed", WDT_RESET_REQ, 32'h1);
      // hardware start option
      HARDWARE_START_OPTION <= 1'b1;
      sys_reset();
      cyc(2);
      chk("hw_start", WDT_RUNNING, 32'h1);
      HARDWARE_START_OPTION <= 1'b0;
      // debug freeze, then oscillator not ready
      for (int k = 0; k < 2; k++) begin
         sys_reset();
         wr(KEY_ADDR, {16'h0, KEY_UNLOCK});
         wr(RELOAD_ADDR, 32'h1);
         cyc(48);
         if (k == 0) begin
            DEBUG_HALT       <= 1'b1;
            DEBUG_FREEZE_SEL <= 1'b1;
         end else begin
            SLOW_OSC_READY   <= 1'b0;
         end
         wr(KEY_ADDR, {16'h0, KEY_START});
         wait_fire(400, n);
         chk("held", WDT_RESET_REQ, 32'h0);
         DEBUG_FREEZE_SEL <= 1'b0;
         SLOW_OSC_READY   <= 1'b1;
         wait_fire(100, n);
         chk("released", WDT_RESET_REQ, 32'h1);
         DEBUG_HALT       <= 1'b0;
      end
      // power-on reset clears the cause flag
      sys_reset();
      POWER_ON_RST <= 1'b1;
      cyc(1);
      POWER_ON_RST <= 1'b0;
      cyc(2);
      chk("por_clr", WATCHDOG_RESET_CAUSE_FLAG, 32'h0);
      final_report();
   end
endmodule : tb
